//--- rtl/gate_ctrl_defines.vh
`ifndef GATE_CTRL_DEFINES_VH
`define GATE_CTRL_DEFINES_VH
// Serial frame layout, MSB first
`define FRAME_BITS 16
`define FRAME_CNT_W 5
`define FRAME_LAST 5'h10
`define DAC_MSB 7
`define DAC_LSB 0
`define DAC_W 8
`define DAC_RESET 8'h00
`endif

//--- rtl/spi_dac_current_limit_gate_control.v
// Functional notes
// - Disable input high keeps second output off
// - Disable takes effect once PWM is low
// - PWM high drives enabled main outputs high
// - PWM low or trip forces outputs low
// - Blanking low grounds comparator, no trip
// - Blanking input pulled up when undriven
// - DAC above sense holds comparator low
// - Sense above DAC raises flag, outputs low
// - Trip latched until sense low, PWM rises
// - Eight-bit DAC code sets limit threshold
// - Select low, shift data on clock falls
// - Sixteenth falling edge updates DAC immediately
// - Extra clocks after sixteenth are ignored
// - Zero-volt output low when node below supply
`timescale 1ns/1ps
`default_nettype none
`include "gate_ctrl_defines.vh"

module spi_dac_current_limit_gate_control (
    input wire clk,
    input wire arst_n,
    input wire pwm_in,
    input wire aux_drive_input,
    input wire second_driver_disable_n,
    input wire sense_blank_n,
    input wire sense_blank_n_oe,
    input wire [7:0] current_sense_in,
    input wire serial_select_n,
    input wire serial_clk,
    input wire serial_data_in,
    input wire serial_addr_pin,
    input wire zero_volt_pos_in,
    input wire zero_volt_neg_in,
    output reg main_gate_out_a,
    output reg main_gate_out_b,
    output reg aux_gate_out,
    output reg overcurrent_flag,
    output reg [7:0] dac_code_out,
    output reg zero_volt_detect
);

    // Two-flop synchronisers for every pin input except the unused serial_addr_pin
    reg [1:0] pwm_s_ff;
    reg [1:0] aux_s_ff;
    reg [1:0] dis_s_ff;
    reg [1:0] blk_s_ff;
    reg [1:0] cs_s_ff;
    reg [1:0] sck_s_ff;
    reg [1:0] din_s_ff;
    reg [1:0] zvp_s_ff;
    reg [1:0] zvn_s_ff;
    reg [7:0] sense_m_ff;
    reg [7:0] sense_s_ff;
    reg [7:0] sense_q_ff;
    reg pwm_d_ff;
    reg sck_d_ff;
    reg cs_d_ff;
    reg b_en_ff;
    reg trip_ff;
    reg [`FRAME_BITS-1:0] shift_ff;
    reg [`FRAME_CNT_W-1:0] cnt_ff;

    // Undriven blanking pin reads high through the pull-up
    wire blank_pin = sense_blank_n_oe ? sense_blank_n : 1'b1;

    // PWM level synchroniser
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pwm_s_ff <= 2'h0;
        end
        else
        begin
            pwm_s_ff <= {pwm_s_ff[0], pwm_in};
        end
    end

    // Auxiliary drive synchroniser
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aux_s_ff <= 2'h0;
        end
        else
        begin
            aux_s_ff <= {aux_s_ff[0], aux_drive_input};
        end
    end

    // Second-driver disable synchroniser
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dis_s_ff <= 2'h0;
        end
        else
        begin
            dis_s_ff <= {dis_s_ff[0], second_driver_disable_n};
        end
    end

    // Blanking synchroniser; resets to the pulled-up idle level
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            blk_s_ff <= 2'h3;
        end
        else
        begin
            blk_s_ff <= {blk_s_ff[0], blank_pin};
        end
    end

    // Select synchroniser; idle high so no false frame start after reset
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cs_s_ff <= 2'h3;
        end
        else
        begin
            cs_s_ff <= {cs_s_ff[0], serial_select_n};
        end
    end

    // Serial clock synchroniser; a rise after reset is harmless, only falls shift
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sck_s_ff <= 2'h0;
        end
        else
        begin
            sck_s_ff <= {sck_s_ff[0], serial_clk};
        end
    end

    // Serial data synchroniser, same depth as the clock so bits stay aligned
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            din_s_ff <= 2'h0;
        end
        else
        begin
            din_s_ff <= {din_s_ff[0], serial_data_in};
        end
    end

    // Zero-volt comparator input synchronisers
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            zvp_s_ff <= 2'h0;
            zvn_s_ff <= 2'h0;
        end
        else
        begin
            zvp_s_ff <= {zvp_s_ff[0], zero_volt_pos_in};
            zvn_s_ff <= {zvn_s_ff[0], zero_volt_neg_in};
        end
    end

    // Sense word, two stages deep
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sense_m_ff <= 8'h00;
            sense_s_ff <= 8'h00;
        end
        else
        begin
            sense_m_ff <= current_sense_in;
            sense_s_ff <= sense_m_ff;
        end
    end

    // A multi-bit word may be caught mid-change; accept it only once two
    // stages agree, trading one cycle of trip latency for a clean value
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sense_q_ff <= 8'h00;
        end
        else if (sense_m_ff == sense_s_ff)
        begin
            sense_q_ff <= sense_s_ff;
        end
    end

    wire pwm = pwm_s_ff[1];
    wire pwm_rise = pwm & ~pwm_d_ff;
    wire pwm_fall = ~pwm & pwm_d_ff;
    wire sck_fall = ~sck_s_ff[1] & sck_d_ff;
    wire cs_fall = ~cs_s_ff[1] & cs_d_ff;
    // Blanked comparator sees ground on its positive input, never trips
    wire cmp_out = blk_s_ff[1] & (sense_q_ff > dac_code_out);
    wire nxt_trip = cmp_out | (trip_ff & ~(pwm_rise & ~cmp_out));

    // Serial receiver; counter saturates so later edges do nothing
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sck_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
            shift_ff <= 16'h0000;
            cnt_ff <= 5'h00;
            dac_code_out <= `DAC_RESET;
        end
        else
        begin
            sck_d_ff <= sck_s_ff[1];
            cs_d_ff <= cs_s_ff[1];
            if (cs_fall)
                cnt_ff <= 5'h00;
            else if (!cs_s_ff[1] && sck_fall && cnt_ff != `FRAME_LAST)
            begin
                shift_ff <= {shift_ff[`FRAME_BITS-2:0], din_s_ff[1]};
                cnt_ff <= cnt_ff + 5'h01;
                if (cnt_ff == `FRAME_LAST - 5'h01)
                    dac_code_out <= {shift_ff[`DAC_MSB-1:`DAC_LSB], din_s_ff[1]};
            end
        end
    end

    // PWM history for edge detection; reset matches the idle low level
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pwm_d_ff <= 1'b0;
        end
        else
        begin
            pwm_d_ff <= pwm;
        end
    end

    // Trip latch and flag; a new trip wins over a release in the same cycle
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trip_ff <= 1'b0;
            overcurrent_flag <= 1'b0;
        end
        else
        begin
            trip_ff <= nxt_trip;
            overcurrent_flag <= nxt_trip;
        end
    end

    // Enable goes on at once, off only while PWM is low so no pulse is cut
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            b_en_ff <= 1'b0;
        end
        else if (!dis_s_ff[1])
        begin
            b_en_ff <= 1'b1;
        end
        else if (pwm_fall || !pwm)
        begin
            b_en_ff <= 1'b0;
        end
    end

    // Main outputs follow PWM unless tripped, B only while enabled; the trip term is the next
    // value so the cut lands in the same cycle as the flag
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            main_gate_out_a <= 1'b0;
            main_gate_out_b <= 1'b0;
        end
        else
        begin
            main_gate_out_a <= pwm & ~nxt_trip;
            main_gate_out_b <= pwm & ~nxt_trip & (b_en_ff | ~dis_s_ff[1]);
        end
    end

    // Auxiliary output follows its own input only
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aux_gate_out <= 1'b0;
        end
        else
        begin
            aux_gate_out <= aux_s_ff[1];
        end
    end

    // Zero-volt output low only while the node sits below the supply
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            zero_volt_detect <= 1'b1;
        end
        else
        begin
            zero_volt_detect <= ~(~zvp_s_ff[1] & zvn_s_ff[1]);
        end
    end

endmodule // spi_dac_current_limit_gate_control
`default_nettype wire

//--- bench/gate_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module gate_ctrl_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pwm_in,
    input wire logic second_driver_disable_n,
    input wire logic sense_blank_n,
    input wire logic sense_blank_n_oe,
    input wire logic main_gate_out_a,
    input wire logic main_gate_out_b,
    input wire logic overcurrent_flag,
    input wire logic zero_volt_detect,
    input wire logic zero_volt_pos_in,
    input wire logic zero_volt_neg_in,
    input wire logic [7:0] current_sense_in,
    input wire logic [7:0] dac_code_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Undriven blanking pin reads high; windows of three to six cycles cover the synchronisers
    wire blk = sense_blank_n | ~sense_blank_n_oe;
    wire hi = current_sense_in > dac_code_out;
    AST_LOW: assert property ((!pwm_in)[*6]
        |-> !main_gate_out_a && !main_gate_out_b) else $error("gate on");
    AST_ON: assert property ((pwm_in && !hi && !overcurrent_flag)[*6]
        |-> main_gate_out_a) else $error("gate off");
    AST_TRIP: assert property ((hi && blk)[*4]
        |-> ##[0:4] overcurrent_flag) else $error("no trip");
    AST_NOTRIP: assert property ((!blk || !hi)[*6]
        |=> !$rose(overcurrent_flag)) else $error("false trip");
    AST_OFF: assert property (overcurrent_flag[*3]
        |-> !main_gate_out_a && !main_gate_out_b) else $error("on in trip");
    AST_HOLD: assert property ((overcurrent_flag && $stable(pwm_in))[*6]
        |=> overcurrent_flag) else $error("trip lost");
    AST_BOFF: assert property ((second_driver_disable_n && !pwm_in)[*6]
        ##1 second_driver_disable_n[*6] |-> !main_gate_out_b) else $error("b on");
    AST_DEFER: assert property ((pwm_in[*4] ##0 ($rose(second_driver_disable_n)
        && main_gate_out_b)) ##1 pwm_in[*3] |-> main_gate_out_b) else $error("b early");
    AST_ZV: assert property ((!zero_volt_pos_in && zero_volt_neg_in)[*4]
        |-> !zero_volt_detect) else $error("zv high");
    AST_ZVHI: assert property ((zero_volt_pos_in || !zero_volt_neg_in)[*4]
        |-> zero_volt_detect) else $error("zv low");
endmodule // gate_ctrl_props
bind spi_dac_current_limit_gate_control gate_ctrl_props PROPS (.*);
`default_nettype wire

//--- bench/spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    output logic serial_select_n = 1,
    output logic serial_clk = 1,
    output logic serial_data_in = 0
);
    // Clock stands high outside frames; data inverts after the last clock rise, before select is released
    task send(input logic [23:0] w, input int n);
        serial_select_n = 0;
        for (int i = 23; i > 23 - n; i--)
        begin
            serial_data_in = w[i];
            #40 serial_clk = 0;
            #40 serial_clk = 1;
        end
        serial_data_in = ~serial_data_in;
        #40 serial_select_n = 1;
        #80;
    endtask
endmodule // spi_host
`default_nettype wire

//--- bench/spi_dac_current_limit_gate_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module spi_dac_current_limit_gate_control_test;
    logic clk = 0, arst_n = 0, pwm_in = 0, aux_drive_input = 0, serial_addr_pin = 0;
    logic second_driver_disable_n = 0, sense_blank_n = 1, sense_blank_n_oe = 0;
    logic zero_volt_pos_in = 1, zero_volt_neg_in = 0, serial_select_n, serial_clk;
    logic serial_data_in, main_gate_out_a, main_gate_out_b, aux_gate_out;
    logic overcurrent_flag, zero_volt_detect;
    logic [7:0] current_sense_in = 8'h00, dac_code_out;
    int fails = 0, checked = 0;
    spi_host HOST (.*);
    spi_dac_current_limit_gate_control DUT (.*);
    initial forever #4 clk = ~clk;
    task w(input int n); repeat (n) @(negedge clk); endtask
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %0t %h %h", $time, got, exp);
        end
    endtask
    task summarize;
        if (fails == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog, far beyond the few microseconds the sequence needs
    initial begin #60000; fails++; summarize; end
    initial
    begin
        w(16); arst_n = 1; w(3);
        cmp(dac_code_out, 8'h00);
        cmp(zero_volt_detect, 8'h01);
        HOST.send({16'h5aa5, 8'h00}, 16); w(6); cmp(dac_code_out, 8'ha5);
        HOST.send(24'h003cc3, 24); w(6); cmp(dac_code_out, 8'h3c);
        aux_drive_input = 1; pwm_in = 1; w(6);
        cmp({main_gate_out_a, main_gate_out_b, aux_gate_out}, 8'h07);
        pwm_in = 0; w(6); cmp({main_gate_out_a, main_gate_out_b}, 8'h00);
        pwm_in = 1; w(6); second_driver_disable_n = 1; w(6); cmp(main_gate_out_b, 8'h01);
        pwm_in = 0; w(6); pwm_in = 1; w(6);
        cmp({main_gate_out_a, main_gate_out_b}, 8'h02);
        second_driver_disable_n = 0; sense_blank_n_oe = 1; sense_blank_n = 0;
        current_sense_in = 8'h50; w(6); cmp(overcurrent_flag, 8'h00);
        sense_blank_n_oe = 0; sense_blank_n = 1; w(6);
        cmp({overcurrent_flag, main_gate_out_a}, 8'h02);
        current_sense_in = 8'h10; w(6); cmp(overcurrent_flag, 8'h01);
        pwm_in = 0; w(6); pwm_in = 1; w(6);
        cmp({overcurrent_flag, main_gate_out_a}, 8'h01);
        zero_volt_pos_in = 0; zero_volt_neg_in = 1; w(6); cmp(zero_volt_detect, 8'h00);
        summarize;
    end
endmodule // spi_dac_current_limit_gate_control_test
`default_nettype wire
